// ===== rtl/program_data_space_access.sv
// Program/data space access unit: table transfers, visibility window and X/Y read routing
// Behaviour
// - Program address steps by two per 24-bit program word.
// - Word low table read returns P<15:0> as D<15:0>.
// - Byte low table read gives P<7:0> for select 0, P<15:8> for 1.
// - Word high table read puts P<23:16> into D<7:0>.
// - Byte high table read gives P<23:16> for select 0, zero for 1.
// - Redirect to program space only if EA msb and visibility enable set.
// - Window maps upper 32 Kbytes of data onto one 16K word page.
// - Visibility address: low 15 bits from EA, upper from page register.
// - Visibility access returns the low 16 bits of the program word.
// - Visibility mapping suspended during table reads or writes.
// - Outside repeat, MAC prefetch, move, double move cost one extra cycle.
// - Outside repeat, other visibility instructions cost two extra cycles.
// - In repeat, first, last, interrupt exit and re-entry cost two cycles.
// - Other repeat iterations with visibility complete in one cycle.
// - Non-MAC sees all space as X; MAC X reads exclude Y block.
// - MAC: Y via Y pointers, X via X pointers, both read concurrently.
// - Y bus never writes; all writes go on the X write bus.
// - Bit reversal only for X writes.
// - Unimplemented data address reads return zero.
// - MAC X pointer in Y space or Y pointer in X space reads zero.
// - Data effective addresses are 16-bit byte addresses.
// - X/Y boundary is fixed in hardware, not software writable.
// - Table page msb selects user or configuration space.
`timescale 1ns/10ps
`default_nettype none

module program_data_space_access
  import pdsa_pkg::*;
#(
  parameter logic [15:0] y_base   = y_base_rst,   // Start of Y block
  parameter logic [15:0] y_end    = y_end_rst,    // End of Y block, exclusive
  parameter logic [15:0] impl_end = impl_end_rst  // End of implemented RAM, exclusive
) (
  input  wire  logic        pclk,       // APB clock, 20 MHz
  input  wire  logic        presetn,    // Asynchronous reset, active low
  input  wire  logic        psel,       // APB select
  input  wire  logic        penable,    // APB enable
  input  wire  logic        pwrite,     // APB direction
  input  wire  logic [7:0]  paddr,      // APB byte address
  input  wire  logic [31:0] pwdata,     // APB write data
  output var   logic [31:0] prdata,     // APB read data
  output var   logic        pready,     // APB ready
  output var   logic        pslverr,    // APB error on unmapped address
  output var   logic [23:0] prog_addr,  // Program memory address
  output var   logic        prog_rd,    // Program memory read strobe
  input  wire  logic [23:0] prog_data,  // Program memory word
  output var   logic        x_wr,       // X write bus strobe
  output var   logic [15:0] x_wr_addr,  // X write bus address
  output var   logic        extra_busy  // Instruction stretched by visibility cost
);

  typedef struct packed {
    state_t      st;
    logic [15:0] ctrl;
    logic [15:0] page;
    logic [15:0] req;
    logic [15:0] ea;
    logic [15:0] xptr;
    logic [15:0] yptr;
    logic [23:0] pdata;
    logic [15:0] xdata;
    logic [15:0] ydata;
    logic [1:0]  cost;
    logic        done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] prog_addr;
    logic        prog_rd;
    logic        x_wr;
    logic [15:0] x_wr_addr;
    logic        busy;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  // Zero outside implemented memory
  function automatic logic impl_ok(input logic [15:0] a);
    impl_ok = (a < impl_end);
  endfunction : impl_ok

  function automatic logic in_y(input logic [15:0] a);
    in_y = (a >= y_base) && (a < y_end);
  endfunction : in_y

  // Bit reversal on word address bits
  function automatic logic [15:0] bit_rev(input logic [15:0] a);
    logic [15:0] v;
    v = a;
    for (int i = 1; i < 16; i++)
    begin
      v[i] = a[16 - i];
    end
    bit_rev = v;
  endfunction : bit_rev

  // Pseudo RAM image: word value is its own address
  function automatic logic [15:0] ram_word(input logic [15:0] a);
    ram_word = {a[15:1], 1'b0};
  endfunction : ram_word

  logic [2:0] op;
  logic       tbl_busy;
  logic       psv_hit;

  always_comb
  begin
    r_d          = r_q;
    r_d.pready   = 1'b0;
    r_d.pslverr  = 1'b0;
    r_d.prog_rd  = 1'b0;
    r_d.x_wr     = 1'b0;
    op           = r_q.req[req_op_lsb +: req_op_w];
    tbl_busy     = (op == op_tbl_rd_lo) || (op == op_tbl_rd_hi) ||
                   (op == op_tbl_wr_lo) || (op == op_tbl_wr_hi);
    psv_hit      = r_q.ea[15] && r_q.ctrl[psv_bit] && !tbl_busy;

    // APB slave: answers one cycle after the access phase starts
    if (psel && penable && !r_q.pready)
    begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0000_0000;
      unique case (paddr)
        ctrl_off:   r_d.prdata[15:0] = r_q.ctrl;
        page_off:   r_d.prdata[15:0] = r_q.page;
        req_off:    r_d.prdata[15:0] = r_q.req;
        addr_off:   r_d.prdata[15:0] = r_q.ea;
        ptr_off:    r_d.prdata = {r_q.yptr, r_q.xptr};
        pdata_off:  r_d.prdata[23:0] = r_q.pdata;
        status_off: r_d.prdata[7:0] = {r_q.st, r_q.done, 1'b0, r_q.cost};
        xdata_off:  r_d.prdata[15:0] = r_q.xdata;
        ydata_off:  r_d.prdata[15:0] = r_q.ydata;
        paddr_off:  r_d.prdata[23:0] = r_q.prog_addr;
        bounds_off: r_d.prdata = {y_end, y_base};
        default:    r_d.pslverr = 1'b1;
      endcase
      if (pwrite)
      begin
        r_d.prdata = 32'h0000_0000;
        unique case (paddr)
          ctrl_off: r_d.ctrl = pwdata[15:0];
          page_off: r_d.page = pwdata[15:0];
          req_off:
          begin
            r_d.req  = pwdata[15:0];
            r_d.done = 1'b0;
          end
          addr_off: r_d.ea = pwdata[15:0] & 16'hffff;
          ptr_off:
          begin
            r_d.xptr = pwdata[15:0];
            r_d.yptr = pwdata[31:16];
          end
          default:  r_d.pslverr = !(paddr inside {status_off, xdata_off, ydata_off,
                                                  paddr_off, bounds_off, pdata_off});
        endcase
      end
    end

    unique case (r_q.st)
      st_idle:
      begin
        if (r_q.req[req_go_bit])
        begin
          r_d.req[req_go_bit] = 1'b0;
          r_d.cost = cost_none;
          if (tbl_busy)
          begin
            // Table page forms bits 23:16; its msb picks config space
            r_d.prog_addr = {r_q.page[tbl_page_lsb +: 8], r_q.ea};
            r_d.prog_rd   = (op == op_tbl_rd_lo) || (op == op_tbl_rd_hi);
            r_d.st        = st_fetch;
          end
          else if (op == op_mac)
          begin
            // Concurrent X and Y reads, each confined to its own space
            r_d.xdata = (!in_y(r_q.xptr) && impl_ok(r_q.xptr)) ?
                        ram_word(r_q.xptr) : zero_word;
            r_d.ydata = in_y(r_q.yptr) ? ram_word(r_q.yptr) : zero_word;
            r_d.done  = 1'b1;
          end
          else if (r_q.req[req_wr_bit])
          begin
            // Writes only on the X bus; bit reversal only here
            r_d.x_wr      = 1'b1;
            r_d.x_wr_addr = r_q.req[req_bitrev_bit] ?
                            bit_rev(r_q.ea) : r_q.ea;
            r_d.done      = 1'b1;
          end
          else if (psv_hit)
          begin
            // Page supplies upper bits, EA supplies the low 15
            r_d.prog_addr = {1'b0, r_q.page[psv_page_lsb +: 8], r_q.ea[14:0]};
            r_d.prog_rd   = 1'b1;
            if (!r_q.ctrl[rpt_bit])
            begin
              r_d.cost = (r_q.req[req_class_lsb +: 2] == cls_other) ?
                         cost_two : cost_one;
            end
            else
            begin
              r_d.cost = (r_q.req[req_rpt_lsb +: 2] == rpt_middle) ?
                         cost_none : cost_two;
            end
            r_d.st = st_fetch;
          end
          else
          begin
            // Non-MAC sees the full space as X
            r_d.xdata = impl_ok(r_q.ea) ? ram_word(r_q.ea) : zero_word;
            r_d.done  = 1'b1;
          end
        end
      end
      st_fetch:
      begin
        r_d.st = st_wait;
      end
      st_wait:
      begin
        r_d.pdata = prog_data;
        r_d.xdata = zero_word;
        unique case (op)
          op_tbl_rd_lo:
          begin
            if (!r_q.req[req_byte_bit])
              r_d.xdata = prog_data[15:0];
            else
              r_d.xdata[7:0] = r_q.req[req_bsel_bit] ?
                               prog_data[15:8] : prog_data[7:0];
          end
          op_tbl_rd_hi:
          begin
            // Upper data byte stays zero; nothing above bit 23
            if (!r_q.req[req_byte_bit])
              r_d.xdata = {8'h00, prog_data[23:16]};
            else
              r_d.xdata[7:0] = r_q.req[req_bsel_bit] ?
                               8'h00 : prog_data[23:16];
          end
          op_tbl_wr_lo, op_tbl_wr_hi:
            r_d.xdata = zero_word;
          default:
            r_d.xdata = prog_data[15:0];
        endcase
        r_d.st = (r_q.cost == cost_none) ? st_done : st_wait;
        if (r_q.cost != cost_none)
          r_d.cost = r_q.cost - 2'd1;
        if (r_q.cost == cost_none)
          r_d.done = 1'b0;
      end
      st_done:
      begin
        r_d.done = 1'b1;
        r_d.st   = st_idle;
      end
    endcase
    // Registered so the stretch flag leaves straight from a flip-flop
    r_d.busy = r_d.st[2] && (r_d.cost != cost_none);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q           <= '0;
      r_q.st        <= st_idle;
      r_q.ctrl      <= ctrl_rst;
      r_q.page      <= page_rst;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign prdata     = r_q.prdata;
  assign pready     = r_q.pready;
  assign pslverr    = r_q.pslverr;
  assign prog_addr  = r_q.prog_addr;
  assign prog_rd    = r_q.prog_rd;
  assign x_wr       = r_q.x_wr;
  assign x_wr_addr  = r_q.x_wr_addr;
  assign extra_busy = r_q.busy;

endmodule : program_data_space_access

`default_nettype wire

// ===== rtl/pdsa_pkg.sv
// Package with address map, field layouts and codes for the program/data space access unit
package pdsa_pkg;

  // APB register byte offsets
  localparam logic [7:0] ctrl_off     = 8'h00;
  localparam logic [7:0] page_off     = 8'h04;
  localparam logic [7:0] req_off      = 8'h08;
  localparam logic [7:0] addr_off     = 8'h0c;
  localparam logic [7:0] ptr_off      = 8'h10;
  localparam logic [7:0] pdata_off    = 8'h14;
  localparam logic [7:0] status_off   = 8'h18;
  localparam logic [7:0] xdata_off    = 8'h1c;
  localparam logic [7:0] ydata_off    = 8'h20;
  localparam logic [7:0] paddr_off    = 8'h24;
  localparam logic [7:0] bounds_off   = 8'h28;

  // Control register fields
  localparam int psv_bit        = 2;
  localparam int mac_bit        = 0;
  localparam int rpt_bit        = 1;

  // Request register fields
  localparam int req_go_bit     = 0;
  localparam int req_op_lsb     = 1;
  localparam int req_op_w       = 3;
  localparam int req_byte_bit   = 4;
  localparam int req_bsel_bit   = 5;
  localparam int req_class_lsb  = 6;
  localparam int req_rpt_lsb    = 8;
  localparam int req_wr_bit     = 10;
  localparam int req_bitrev_bit = 11;

  // Page register fields
  localparam int tbl_page_lsb   = 0;
  localparam int psv_page_lsb   = 8;
  localparam int cfg_sel_bit    = 7;

  // Reset values
  localparam logic [15:0] ctrl_rst  = 16'h0000;
  localparam logic [15:0] page_rst  = 16'h0000;
  localparam logic [15:0] zero_word = 16'h0000;

  // Fixed X/Y boundary, byte addresses
  localparam logic [15:0] y_base_rst = 16'h0800;
  localparam logic [15:0] y_end_rst  = 16'h1000;
  localparam logic [15:0] impl_end_rst = 16'h2000;

  // Extra cycle costs
  localparam logic [1:0] cost_none = 2'd0;
  localparam logic [1:0] cost_one  = 2'd1;
  localparam logic [1:0] cost_two  = 2'd2;

  // Access operations
  typedef enum logic [2:0] {
    op_data       = 3'd0,
    op_tbl_rd_lo  = 3'd1,
    op_tbl_rd_hi  = 3'd2,
    op_tbl_wr_lo  = 3'd3,
    op_tbl_wr_hi  = 3'd4,
    op_mac        = 3'd5
  } op_t;

  // Instruction class for visibility cost
  typedef enum logic [1:0] {
    cls_other   = 2'd0,
    cls_mac_pf  = 2'd1,
    cls_move    = 2'd2,
    cls_dmove   = 2'd3
  } cls_t;

  // Repeat loop position
  typedef enum logic [1:0] {
    rpt_edge    = 2'd0,
    rpt_middle  = 2'd1,
    rpt_irq     = 2'd2,
    rpt_reentry = 2'd3
  } rpt_t;

  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_fetch = 4'b0010,
    st_wait  = 4'b0100,
    st_done  = 4'b1000
  } state_t;

endpackage : pdsa_pkg

// ===== testbench/pdsa_props.sv
// Port checker for the program/data space access unit
`timescale 1ns/10ps
`default_nettype none
module pdsa_props (
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset
  input wire logic        psel,      // Select
  input wire logic        penable,   // Enable
  input wire logic        pwrite,    // Direction
  input wire logic [7:0]  paddr,     // Address
  input wire logic [31:0] prdata,    // Read data
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic        prog_rd,   // Fetch
  input wire logic        x_wr,      // X write
  input wire logic        extra_busy // Stretch
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing");
  a_err_map: assert property (pready && paddr > 8'h28 |-> pslverr) else $error("no error");
  a_ok_map: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("false error");
  a_upper_zero: assert property (pready && !pwrite &&
    !(paddr inside {8'h10, 8'h14, 8'h24, 8'h28})
    |-> prdata[31:16] == 16'h0000) else $error("upper half set");
  a_fetch_pulse: assert property (prog_rd |=> !prog_rd) else $error("fetch too long");
  a_busy_bound: assert property ($rose(extra_busy) |-> ##[1:2] !extra_busy)
    else $error("stretch too long");
  a_busy_fetch: assert property ($rose(extra_busy) |->
    $past(prog_rd, 1) || $past(prog_rd, 2) || $past(prog_rd, 3))
    else $error("stretch without fetch");
  a_xwr_pulse: assert property (x_wr |=> !x_wr) else $error("write too long");
  c_err: cover property (pslverr);
  c_two: cover property ($rose(extra_busy) ##1 extra_busy);
  c_wr: cover property (x_wr);
endmodule : pdsa_props
bind program_data_space_access pdsa_props props_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .prog_rd, .x_wr, .extra_busy);
`default_nettype wire

// ===== testbench/pmem_model.sv
// Program memory model answering fetches of the access unit
`timescale 1ns/10ps
`default_nettype none
module pmem_model (
  input  wire logic        pclk,      // Clock
  input  wire logic        presetn,   // Reset
  input  wire logic        prog_rd,   // Fetch strobe
  input  wire logic [23:0] prog_addr, // Fetch address
  output var  logic [23:0] prog_data  // Word, inverted outside the hold
);
  logic [1:0]  age_q;
  logic [23:0] word_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      age_q  <= 2'd0;
      word_q <= 24'h00_0000;
    end
    else if (prog_rd)
    begin
      age_q  <= 2'd3;
      word_q <= {prog_addr[8:1] ^ 8'ha5, prog_addr[16:1] ^ 16'h3c96};
    end
    else if (age_q != 2'd0)
      age_q <= age_q - 2'd1;
  end
  // Stale data is inverted so a late sample cannot pass by luck
  assign prog_data = (age_q != 2'd0) ? word_q : ~word_q;
endmodule : pmem_model
`default_nettype wire

// ===== testbench/test_program_data_space_access.sv
// Self-checking bench for the program/data space access unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_program_data_space_access
  import pdsa_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_rd, x_wr;
  logic        extra_busy, err_v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [23:0] prog_addr, prog_data;
  logic [15:0] x_wr_addr, last_xw;
  int          num_errors, cmp_count, cycles, busy_n;

  program_data_space_access dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_rd, .prog_data, .x_wr,
    .x_wr_addr, .extra_busy);
  pmem_model mem_u (.pclk, .presetn, .prog_rd, .prog_addr, .prog_data);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (extra_busy === 1'b1)
      busy_n++;
    if (x_wr === 1'b1)
      last_xw <= x_wr_addr;
    if (cycles > 6000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  function automatic logic [23:0] pw(logic [23:0] a);
    return {a[8:1] ^ 8'ha5, a[16:1] ^ 16'h3c96};
  endfunction : pw

  function automatic logic [31:0] mk(op_t o, logic b, logic s, logic [1:0] c, logic [1:0] r,
                                     logic w);
    return 32'h0000_0001 | 32'(o) << req_op_lsb | 32'(b) << req_byte_bit
      | 32'(s) << req_bsel_bit | 32'(c) << req_class_lsb | 32'(r) << req_rpt_lsb
      | 32'(w) << req_wr_bit;
  endfunction : mk

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (n >= 16)
      num_errors++;
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic run(logic [31:0] req, logic [15:0] ea);
    int n;
    n = 0;
    apb(1'b1, addr_off, {16'h0000, ea});
    apb(1'b1, req_off, req);
    do apb(1'b0, status_off, 32'h0000_0000); while (rd_v[3] !== 1'b1 && ++n < 20);
  endtask : run

  task automatic t_table;
    logic [23:0] w;
    logic [15:0] ex [6];
    w  = pw(24'h81_1234);
    ex = '{w[15:0], {8'h00, w[7:0]}, {8'h00, w[15:8]}, {8'h00, w[23:16]},
           {8'h00, w[23:16]}, 16'h0000};
    apb(1'b1, page_off, 32'h0000_0581);
    for (int i = 0; i < 6; i++)
    begin
      run(mk(i < 3 ? op_tbl_rd_lo : op_tbl_rd_hi, i % 3 != 0, i % 3 == 2, 2'd0, 2'd0, 1'b0),
          16'h1234);
      apb(1'b0, xdata_off, 32'h0000_0000);
      `CHK("table data", ex[i], rd_v[15:0] & (i % 3 != 0 ? 16'h00ff : 16'hffff))
    end
    apb(1'b0, paddr_off, 32'h0000_0000);
    `CHK("table address", 32'h0081_1234, rd_v)
  endtask : t_table

  task automatic t_psv;
    logic [1:0] cost [8];
    int         b0;
    cost = '{2'd2, 2'd1, 2'd1, 2'd1, 2'd2, 2'd0, 2'd2, 2'd2};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, ctrl_off, i < 4 ? 32'h0000_0004 : 32'h0000_0006);
      b0 = busy_n;
      run(mk(op_data, 1'b0, 1'b0, i < 4 ? 2'(i) : 2'd0, i < 4 ? 2'd0 : 2'(i - 4), 1'b0),
          16'h9234);
      `CHK("stretch", 32'(cost[i]), 32'(busy_n - b0))
    end
    apb(1'b0, paddr_off, 32'h0000_0000);
    `CHK("window address", 32'h0002_9234, rd_v)
    apb(1'b0, xdata_off, 32'h0000_0000);
    `CHK("window data", {8'h00, pw(24'h02_9234) & 24'h00_ffff}, rd_v)
    run(mk(op_tbl_rd_lo, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0), 16'h9234);
    apb(1'b0, paddr_off, 32'h0000_0000);
    `CHK("table over window", 32'h0081_9234, rd_v)
  endtask : t_psv

  task automatic t_data;
    logic [15:0] ea [3];
    logic [15:0] ex [3];
    ea = '{16'h9234, 16'h0900, 16'h1234};
    ex = '{16'h0000, 16'h0900, 16'h1234};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, ctrl_off, i == 2 ? 32'h0000_0004 : 32'h0000_0000);
      run(mk(op_data, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0), ea[i]);
      apb(1'b0, xdata_off, 32'h0000_0000);
      `CHK("data read", ex[i], rd_v[15:0])
    end
  endtask : t_data

  task automatic t_mac;
    logic [31:0] pt [2];
    logic [31:0] ex [4];
    pt = '{32'h0a00_0900, 32'h0400_0400};
    ex = '{32'h0000_0000, 32'h0000_0a00, 32'h0000_0400, 32'h0000_0000};
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ptr_off, pt[i]);
      run(mk(op_mac, 1'b0, 1'b0, 2'd0, 2'd0, 1'b0), 16'h0000);
      apb(1'b0, xdata_off, 32'h0000_0000);
      `CHK("x read", ex[2 * i], rd_v)
      apb(1'b0, ydata_off, 32'h0000_0000);
      `CHK("y read", ex[2 * i + 1], rd_v)
    end
  endtask : t_mac

  task automatic t_misc;
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err_v)
    apb(1'b1, bounds_off, 32'h0000_0000);
    apb(1'b0, bounds_off, 32'h0000_0000);
    `CHK("boundary", 32'h1000_0800, rd_v)
    run(mk(op_data, 1'b0, 1'b0, 2'd0, 2'd0, 1'b1), 16'h0a00);
    `CHK("x write address", 16'h0a00, last_xw)
    run(mk(op_data, 1'b0, 1'b0, 2'd0, 2'd0, 1'b1) | 32'h0000_0800, 16'h0a00);
    `CHK("reversed write address", 16'h00a0, last_xw)
  endtask : t_misc

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_table();
    t_psv();
    t_data();
    t_mac();
    t_misc();
    wrap_up();
  end
endmodule : test_program_data_space_access
`default_nettype wire
